/* src/ftsr_map.svh */
`ifndef FTSR_MAP_SVH
`define FTSR_MAP_SVH

// Geometry of the array
`define FTSR_WORDS      1048576
`define FTSR_ADDR_W     20
`define FTSR_DATA_W     36
`define FTSR_LANES      4
`define FTSR_LANE_W     9
`define FTSR_BEAT_W     2

// Write record stream buffer
`define FTSR_LOG_DEPTH  8
`define FTSR_LOG_W      60

// Pin synchroniser, bit order {outputEnableN, sleepRequest, burstOrderSelect}
`define FTSR_SYNC_W     3
`define FTSR_SYNC_RST   3'h5
`define FTSR_SYNC_OE    2
`define FTSR_SYNC_SLEEP 1
`define FTSR_SYNC_ORDER 0

`endif

/* src/ftsr_pkg.sv */
`default_nettype none

package ftsr_pkg;

	// Operation carried by the current beat, Gray coded along deselect-read-write
	typedef enum logic [1:0] {
		ST_DESEL = 2'h0,
		ST_READ  = 2'h1,
		ST_WRITE = 2'h3
	} ftsr_state_type;

endpackage : ftsr_pkg

`default_nettype wire

/* src/ftsr_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module ftsr_fifo #(
	parameter int WIDTH = 60,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [PW-1:0]    wrPtr_reg;
	logic [PW-1:0]    rdPtr_reg;
	logic [PW-1:0]    rdPtr_next;
	logic [PW:0]      count_reg;
	logic [PW:0]      count_next;
	logic             push;
	logic             pop;

	// Full comes from the count, so it stays honest under back-pressure
	assign inReady = (count_reg < (PW+1)'(DEPTH));
	assign push    = inValid && inReady;
	assign pop     = outValid && outReady;

	// Next read pointer and occupancy
	always_comb begin
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (pop) begin
			rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			store_reg[wrPtr_reg] <= inData;
		end
	end

	// Pointers, occupancy and a registered valid flag
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			outValid  <= 1'b0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
			outValid  <= (count_next != '0);
		end
	end

	// Head word from a register; a push into the slot read next goes straight through
	always_ff @(posedge clk) begin
		if (push && (wrPtr_reg == rdPtr_next)) begin
			outData <= inData;
		end else begin
			outData <= store_reg[rdPtr_next];
		end
	end

endmodule : ftsr_fifo

`default_nettype wire

/* src/ftsr_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ftsr_map.svh"

module ftsr_mem (
	input  wire logic                      clk,
	input  wire logic                      wrEn,
	input  wire logic [`FTSR_ADDR_W-1:0]   wrAddr,
	input  wire logic [`FTSR_LANES-1:0]    wrLanesN,
	input  wire logic [`FTSR_DATA_W-1:0]   wrData,
	input  wire logic                      rdEn,
	input  wire logic [`FTSR_ADDR_W-1:0]   rdAddr,
	output logic [`FTSR_DATA_W-1:0]        rdData
);
	logic [`FTSR_DATA_W-1:0] array_reg [`FTSR_WORDS];

	// Lane-masked write; contents are retained, never reset
	always_ff @(posedge clk) begin
		if (wrEn) begin
			for (int i = 0; i < `FTSR_LANES; i++) begin
				if (!wrLanesN[i]) begin
					array_reg[wrAddr][i*`FTSR_LANE_W +: `FTSR_LANE_W] <=
						wrData[i*`FTSR_LANE_W +: `FTSR_LANE_W];
				end
			end
		end
	end

	// Registered read, write-first so a read right behind a write sees it
	always_ff @(posedge clk) begin
		if (rdEn) begin
			for (int i = 0; i < `FTSR_LANES; i++) begin
				if (wrEn && !wrLanesN[i] && (wrAddr == rdAddr)) begin
					rdData[i*`FTSR_LANE_W +: `FTSR_LANE_W] <=
						wrData[i*`FTSR_LANE_W +: `FTSR_LANE_W];
				end else begin
					rdData[i*`FTSR_LANE_W +: `FTSR_LANE_W] <=
						array_reg[rdAddr][i*`FTSR_LANE_W +: `FTSR_LANE_W];
				end
			end
		end
	end

endmodule : ftsr_mem

`default_nettype wire

/* src/ftsr_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ftsr_map.svh"

module ftsr_top (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic [`FTSR_ADDR_W-1:0]   address,
	input  wire logic                      readWriteSel,
	input  wire logic [`FTSR_LANES-1:0]    byteLaneWriteEnableN,
	input  wire logic                      chipSelect0N,
	input  wire logic                      chipSelect1,
	input  wire logic                      chipSelect2N,
	input  wire logic                      burstAdvanceLoad,
	input  wire logic                      burstOrderSelect,
	input  wire logic                      clockHoldGate,
	input  wire logic                      sleepRequest,
	input  wire logic                      outputEnableN,
	input  wire logic [`FTSR_DATA_W-1:0]   dqIn,
	output logic [`FTSR_DATA_W-1:0]        dqOut,
	output logic                           dqOeN,
	output logic                           logValid,
	input  wire logic                      logReady,
	output logic [`FTSR_LOG_W-1:0]         logData,
	output logic                           logRoom
);

	// ------------------------------------------------------------
	// Pin synchronisers for the asynchronous and static inputs
	// ------------------------------------------------------------
	logic [`FTSR_SYNC_W-1:0] stage1_reg;
	logic [`FTSR_SYNC_W-1:0] stage2_reg;
	logic [`FTSR_SYNC_W-1:0] stage3_reg;
	logic [`FTSR_SYNC_W-1:0] filt_reg;
	logic                    filtOeN;
	logic                    filtSleep;
	logic                    filtOrder;

	// A change is taken only when the last two stages agree, masking glitches
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage1_reg <= `FTSR_SYNC_RST;
			stage2_reg <= `FTSR_SYNC_RST;
			stage3_reg <= `FTSR_SYNC_RST;
			filt_reg   <= `FTSR_SYNC_RST;
		end else begin
			stage1_reg <= {outputEnableN, sleepRequest, burstOrderSelect};
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			filt_reg   <= (filt_reg & (stage2_reg ^ stage3_reg))
				| (stage3_reg & ~(stage2_reg ^ stage3_reg));
		end
	end

	assign filtOeN   = filt_reg[`FTSR_SYNC_OE];
	assign filtSleep = filt_reg[`FTSR_SYNC_SLEEP];
	assign filtOrder = filt_reg[`FTSR_SYNC_ORDER];

	// ------------------------------------------------------------
	// Command decode and burst address
	// ------------------------------------------------------------
	ftsr_pkg::ftsr_state_type  state_reg;
	logic [`FTSR_ADDR_W-1:0]   base_reg;
	logic [`FTSR_BEAT_W-1:0]   beat_reg;
	logic [`FTSR_BEAT_W-1:0]   beat_next;
	logic [`FTSR_BEAT_W-1:0]   burstLow;
	logic [`FTSR_ADDR_W-1:0]   cmdAddr;
	logic                      activeEdge;
	logic                      selected;
	logic                      readBeat;
	logic                      writeBeat;

	// Sleep counts as a held clock: every command and data input is ignored, contents kept
	// hold gating
	assign activeEdge = !clockHoldGate && !filtSleep;

	assign selected = !chipSelect0N && chipSelect1 && !chipSelect2N;

	assign beat_next = beat_reg + 2'h1;
	assign burstLow  = filtOrder ? (base_reg[1:0] ^ beat_next) : (base_reg[1:0] + beat_next);

	assign cmdAddr = burstAdvanceLoad ? {base_reg[`FTSR_ADDR_W-1:2], burstLow} : address;

	always_comb begin
		readBeat  = 1'b0;
		writeBeat = 1'b0;
		if (!burstAdvanceLoad) begin
			readBeat  = selected && readWriteSel;
			writeBeat = selected && !readWriteSel;
		end else begin
			unique case (state_reg)
				ftsr_pkg::ST_DESEL: begin
				end
				ftsr_pkg::ST_READ: begin
					readBeat = 1'b1;
				end
				ftsr_pkg::ST_WRITE: begin
					writeBeat = 1'b1;
				end
			endcase
		end
	end

	// Operation state: loaded on a load edge, kept while advancing
	// load-only sampling
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= ftsr_pkg::ST_DESEL;
		end else if (activeEdge && !burstAdvanceLoad) begin
			if (!selected) begin
				state_reg <= ftsr_pkg::ST_DESEL;
			end else if (readWriteSel) begin
				state_reg <= ftsr_pkg::ST_READ;
			end else begin
				state_reg <= ftsr_pkg::ST_WRITE;
			end
		end
	end

	// Burst base and beat counter
	// counter stepping
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			base_reg <= '0;
			beat_reg <= '0;
		end else if (activeEdge) begin
			if (!burstAdvanceLoad) begin
				base_reg <= address;
				beat_reg <= '0;
			end else begin
				beat_reg <= beat_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Late-write slot
	// ------------------------------------------------------------
	logic                    pendWrite_reg;
	logic [`FTSR_ADDR_W-1:0] pendAddr_reg;
	logic [`FTSR_LANES-1:0]  pendLanesN_reg;
	logic                    memWrEn;
	logic                    memRdEn;
	logic [`FTSR_DATA_W-1:0] memRdData;

	// Lanes are sampled with every write beat, burst beats included
	// command capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pendWrite_reg  <= 1'b0;
			pendAddr_reg   <= '0;
			pendLanesN_reg <= '1;
		end else if (activeEdge) begin
			pendWrite_reg  <= writeBeat;
			pendAddr_reg   <= cmdAddr;
			pendLanesN_reg <= byteLaneWriteEnableN;
		end
	end

	assign memWrEn = activeEdge && pendWrite_reg;
	assign memRdEn = activeEdge && readBeat;

	ftsr_mem u_mem (
		.clk      (clk_sys),
		.wrEn     (memWrEn),
		.wrAddr   (pendAddr_reg),
		.wrLanesN (pendLanesN_reg),
		.wrData   (dqIn),
		.rdEn     (memRdEn),
		.rdAddr   (cmdAddr),
		.rdData   (memRdData)
	);

	// Read data goes out straight from the array's output register
	// flow-through
	assign dqOut = memRdData;

	// ------------------------------------------------------------
	// Data pin enable
	// ------------------------------------------------------------
	// The enable follows the read beat; writes never turn it on, so output
	// enable may stay active throughout. Its pin path is synchronised, so an
	// output enable change is seen three to four clocks late.
	// writes ignore enable
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dqOeN <= 1'b1;
		end else if (filtSleep) begin
			dqOeN <= 1'b1;
		end else if (activeEdge) begin
			dqOeN <= !(readBeat && !filtOeN);
		end
	end

	// ------------------------------------------------------------
	// Completed-write record stream
	// ------------------------------------------------------------
	logic logInReady;

	// A record is dropped when the buffer is full; logRoom warns the consumer
	ftsr_fifo #(
		.WIDTH (`FTSR_LOG_W),
		.DEPTH (`FTSR_LOG_DEPTH)
	) u_log (
		.clk      (clk_sys),
		.rst      (sys_rst),
		.inValid  (memWrEn),
		.inReady  (logInReady),
		.inData   ({pendAddr_reg, pendLanesN_reg, dqIn}),
		.outValid (logValid),
		.outReady (logReady),
		.outData  (logData)
	);

	// Registered room flag
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			logRoom <= 1'b0;
		end else begin
			logRoom <= logInReady;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_writeCmd;
		activeEdge && writeBeat;
	endsequence

	sequence s_dataEdge;
		##1 activeEdge;
	endsequence

	property p_readFlow;
		activeEdge && readBeat && !filtOeN |=> !dqOeN;
	endproperty
	a_readFlow: assert property (p_readFlow) else $error("read beat did not drive data");

	property p_lateWrite;
		s_writeCmd ##0 s_dataEdge |-> memWrEn && (pendAddr_reg == $past(cmdAddr));
	endproperty
	a_lateWrite: assert property (p_lateWrite) else $error("late write missed its slot");

	property p_noGap;
		s_writeCmd ##1 (activeEdge && readBeat) |-> memWrEn && memRdEn;
	endproperty
	a_noGap: assert property (p_noGap) else $error("write then read needed a gap");

	property p_writeCmd;
		s_writeCmd |=> pendWrite_reg && (pendLanesN_reg == $past(byteLaneWriteEnableN));
	endproperty
	a_writeCmd: assert property (p_writeCmd) else $error("write command not registered");

	property p_writeLanes;
		(activeEdge && writeBeat && byteLaneWriteEnableN == 4'h0) ##0 s_dataEdge
			|-> pendLanesN_reg == 4'h0;
	endproperty
	a_writeLanes: assert property (p_writeLanes) else $error("full word write lost a lane");

	property p_deselFloat;
		activeEdge && !burstAdvanceLoad && !selected |=> dqOeN;
	endproperty
	a_deselFloat: assert property (p_deselFloat) else $error("deselected device drove data");

	property p_advanceHolds;
		activeEdge && burstAdvanceLoad |=> $stable(base_reg) && $stable(state_reg);
	endproperty
	a_advanceHolds: assert property (p_advanceHolds) else $error("advance took pin inputs");

	property p_clockHold;
		clockHoldGate |=> $stable(beat_reg) && $stable(pendWrite_reg) && $stable(dqOeN);
	endproperty
	a_clockHold: assert property (p_clockHold) else $error("state moved during clock hold");

	property p_linearOrder;
		burstAdvanceLoad && !filtOrder |-> cmdAddr[1:0] == base_reg[1:0] + beat_reg + 2'h1;
	endproperty
	a_linearOrder: assert property (p_linearOrder) else $error("linear burst order wrong");

	property p_sleepFloat;
		filtSleep |-> !memWrEn ##1 dqOeN;
	endproperty
	a_sleepFloat: assert property (p_sleepFloat) else $error("sleep left data driven");

endmodule : ftsr_top

`default_nettype wire

/* tb/ftsr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ftsr_map.svh"

// ----------------------------------------
// Controller side of the command bus
// ----------------------------------------
module ftsr_host_model (
	input  wire logic                    clk,
	output var logic [`FTSR_ADDR_W-1:0]  address,
	output var logic                     readWriteSel,
	output var logic [`FTSR_LANES-1:0]   byteLaneWriteEnableN,
	output var logic                     chipSelect0N,
	output var logic                     chipSelect1,
	output var logic                     chipSelect2N,
	output var logic                     burstAdvanceLoad,
	output var logic                     clockHoldGate,
	output var logic [`FTSR_DATA_W-1:0]  dqIn
);
	// Start as a deselecting load so the first edges do nothing
	initial begin
		address = 20'h00000;
		readWriteSel = 1'b1;
		byteLaneWriteEnableN = 4'hf;
		{chipSelect0N, chipSelect1, chipSelect2N} = 3'h6;
		burstAdvanceLoad = 1'b0;
		clockHoldGate = 1'b0;
		dqIn = 36'h5a5a5a5a5;
	end

	// One bus cycle launched just after a rising edge, held for the whole cycle
	// 20-bit word address
	task automatic cyc(input logic h, a, r, input logic [1:0] cs, input logic [19:0] ad,
		input logic [3:0] ln, input logic dv, input logic [35:0] d);
		@(posedge clk);
		clockHoldGate <= h;
		burstAdvanceLoad <= a;
		readWriteSel <= r;
		address <= ad;
		byteLaneWriteEnableN <= ln;
		// Code 0 selects, codes 1..3 each spoil one select
		{chipSelect0N, chipSelect1, chipSelect2N} <= 3'h2 ^ (cs == 2'd0 ? 3'h0 : 3'h4 >> (cs - 2'd1));
		// data trails command
		// Released bus shows the inverse so stale data cannot pass for good data
		dqIn <= dv ? d : ~dqIn;
	endtask : cyc
endmodule : ftsr_host_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ftsr_map.svh"

module tb;
	localparam logic [35:0] D0 = 36'h123456789;
	localparam logic [35:0] D1 = 36'hfedcba987;
	localparam logic [35:0] DW = 36'h0a5a5a500;

	logic                      clk_sys, sys_rst, burstOrderSelect, sleepRequest;
	logic                      outputEnableN, logReady, readWriteSel, burstAdvanceLoad;
	logic                      chipSelect0N, chipSelect1, chipSelect2N, clockHoldGate;
	logic                      dqOeN, logValid, logRoom;
	logic [`FTSR_ADDR_W-1:0]   address;
	logic [`FTSR_LANES-1:0]    byteLaneWriteEnableN;
	logic [`FTSR_DATA_W-1:0]   dqIn, dqOut, mrg;
	logic [`FTSR_LOG_W-1:0]    logData;
	int                        mismatches, nTests;

	ftsr_host_model host (.clk(clk_sys), .address, .readWriteSel, .byteLaneWriteEnableN,
		.chipSelect0N, .chipSelect1, .chipSelect2N, .burstAdvanceLoad, .clockHoldGate, .dqIn);

	ftsr_top uut (.clk_sys, .sys_rst, .address, .readWriteSel, .byteLaneWriteEnableN,
		.chipSelect0N, .chipSelect1, .chipSelect2N, .burstAdvanceLoad, .burstOrderSelect,
		.clockHoldGate, .sleepRequest, .outputEnableN, .dqIn, .dqOut, .dqOeN, .logValid,
		.logReady, .logData, .logRoom);

	// Free-running 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [59:0] exp, act);
		nTests++;
		if (act !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, act);
		end
	endtask : check

	// Outputs seen after this launch answer the command of the call before
	task automatic op(input logic h, a, r, input logic [1:0] cs, input logic [19:0] ad,
		input logic [3:0] ln, input logic dv, input logic [35:0] d, input logic c, eo,
		input logic [35:0] ed);
		host.cyc(h, a, r, cs, ad, ln, dv, d);
		@(negedge clk_sys);
		if (c) begin
			check("dqOeN", eo, dqOeN);
			if (!eo) check("dqOut", ed, dqOut);
		end
	endtask : op

	task automatic idle(input int n);
		repeat (n) op(0, 0, 1, 2'd1, 20'h00000, 4'hf, 0, 0, 0, 0, 0);
	endtask : idle

	// Four-beat read with garbage on the ignored pins during advances
	task automatic burst(input logic [1:0] s, input logic il);
		logic [1:0] j;
		for (int b = 0; b < 5; b++) begin
			j = il ? s ^ 2'(b - 1) : s + 2'(b - 1);
			op(0, b > 0 && b < 4, 1, b == 0 ? 2'd0 : 2'd1, b == 0 ? {18'h00008, s} : 20'hfffff,
				4'hf, 0, 0, b > 0, 0, DW + j);
		end
	endtask : burst

	task automatic conclude();
		if (mismatches == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		burstOrderSelect = 1'b0;
		sleepRequest = 1'b0;
		outputEnableN = 1'b0;
		logReady = 1'b0;
		mismatches = 0;
		nTests = 0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		check("dqOeN", 1, dqOeN);
		check("logValid", 0, logValid);
		idle(6);
		// Mixed writes and reads back to back, output enable tied active
		op(0, 0, 0, 0, 20'h00010, 4'h0, 0, 0, 0, 0, 0);
		op(0, 0, 1, 0, 20'h00010, 4'h0, 1, D0, 1, 1, 0);
		op(0, 0, 0, 0, 20'h00011, 4'h0, 0, 0, 1, 0, D0);
		op(0, 0, 1, 0, 20'h00011, 4'h0, 1, D1, 1, 1, 0);
		op(0, 0, 1, 0, 20'h00010, 4'hf, 0, 0, 1, 0, D1);
		op(0, 0, 1, 1, 20'h00000, 4'hf, 0, 0, 1, 0, D0);
		// Partial write: lanes 1 and 3 only
		mrg = {D1[35:27], D0[26:18], D1[17:9], D0[8:0]};
		op(0, 0, 0, 0, 20'h00010, 4'h5, 0, 0, 1, 1, 0);
		op(0, 0, 1, 0, 20'h00010, 4'h0, 1, D1, 1, 1, 0);
		op(0, 0, 1, 1, 20'h00000, 4'h0, 0, 0, 1, 0, mrg);
		// Each select alone deselects; advances keep the deselect
		for (int k = 1; k < 4; k++) begin
			op(0, 0, 1, 0, 20'h00010, 4'h0, 0, 0, 1, 1, 0);
			op(0, 0, 1, k[1:0], 20'h00010, 4'h0, 0, 0, 1, 0, mrg);
			op(0, 1, 1, 0, 20'h00010, 4'h0, 0, 0, 1, 1, 0);
			op(0, 1, 1, 0, 20'h00010, 4'h0, 0, 0, 1, 1, 0);
		end
		// Burst write at 0x20, one data word per beat
		op(0, 0, 0, 0, 20'h00020, 4'h0, 0, 0, 1, 1, 0);
		for (int b = 0; b < 4; b++)
			op(0, b < 3, 1, 1, 20'hfffff, 4'h0, 1, DW + b, 1, 1, 0);
		burst(2'd1, 1'b0);
		@(posedge clk_sys) burstOrderSelect <= 1'b1;
		idle(5);
		burst(2'd2, 1'b1);
		// Held edge carries a write command that must be ignored
		op(0, 0, 1, 0, 20'h00020, 4'hf, 0, 0, 0, 0, 0);
		op(1, 0, 0, 0, 20'hfffff, 4'h0, 0, 0, 1, 0, DW);
		op(0, 1, 1, 1, 20'hfffff, 4'hf, 0, 0, 1, 0, DW);
		op(0, 0, 1, 1, 20'h00000, 4'hf, 0, 0, 1, 0, DW + 1);
		// Late data slot survives a held edge
		op(0, 0, 0, 0, 20'h00030, 4'h0, 0, 0, 1, 1, 0);
		op(1, 0, 1, 1, 20'h00000, 4'h0, 0, 0, 1, 1, 0);
		op(0, 0, 1, 0, 20'h00030, 4'h0, 1, D1, 1, 1, 0);
		op(0, 0, 1, 1, 20'h00000, 4'hf, 0, 0, 1, 0, D1);
		// Ninth record meets a full log while the consumer stalls
		op(0, 0, 0, 0, 20'h00040, 4'h0, 0, 0, 0, 0, 0);
		op(0, 0, 1, 1, 20'h00000, 4'h0, 1, D0, 1, 1, 0);
		idle(2);
		check("logRoom", 0, logRoom);
		check("logData", {20'h00010, 4'h0, D0}, logData);
		@(posedge clk_sys) logReady <= 1'b1;
		repeat (7) @(posedge clk_sys);
		@(negedge clk_sys);
		check("logData", {20'h00030, 4'h0, D1}, logData);
		@(negedge clk_sys);
		check("logValid", 0, logValid);
		check("logRoom", 1, logRoom);
		// Commands during sleep are dropped and the pins float
		@(posedge clk_sys) sleepRequest <= 1'b1;
		idle(5);
		op(0, 0, 0, 0, 20'h00010, 4'h0, 0, 0, 0, 0, 0);
		op(0, 0, 1, 0, 20'h00010, 4'h0, 1, D0, 1, 1, 0);
		op(0, 0, 1, 1, 20'h00000, 4'h0, 0, 0, 1, 1, 0);
		@(posedge clk_sys) sleepRequest <= 1'b0;
		idle(6);
		op(0, 0, 1, 0, 20'h00010, 4'h0, 0, 0, 0, 0, 0);
		op(0, 0, 1, 1, 20'h00000, 4'h0, 0, 0, 1, 0, mrg);
		check("logValid", 0, logValid);
		conclude();
	end

	// Watchdog, far beyond the ninety or so cycles the sequence needs
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule : tb
`default_nettype wire
